// [design/sdv_pkg.sv]
// constants for the storage display view and erase control block
package sdv_pkg;
  // clock
  localparam longint CLK_PERIOD_NS = 8;
  // view, hold and erase times in natural units
  localparam longint VIEW_TIME_S = 100;
  localparam longint HOLD_LIMIT_MIN = 30;
  localparam longint ERASE_WRITE_MS = 14;
  localparam longint ERASE_RESTORE_MS = 950;
  // hold oscillator period and high share in tenths of a percent
  localparam longint HOLD_PERIOD_US = 1000;
  localparam longint HOLD_DUTY_PERMILLE = 123;
  // settle time after an unfiltered coordinate load
  localparam longint SETTLE_NS = 2000;
  // cycle counts derived from the times, least times rounded up
  localparam longint VIEW_CYC = (VIEW_TIME_S * 1000000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // minutes to nanoseconds in steps so no literal leaves 32 bits
  localparam longint HOLD_LIMIT_CYC = (HOLD_LIMIT_MIN * 60 * 1000000000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam longint ERASE_WRITE_CYC = (ERASE_WRITE_MS * 1000000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam longint ERASE_RESTORE_CYC = (ERASE_RESTORE_MS * 1000000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam longint HOLD_PERIOD_CYC = (HOLD_PERIOD_US * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [31:0] SETTLE_CYC = 32'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // widths
  localparam int CW = 40;
  localparam int TW = 32;
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CURSOR_TIME = 4'h4;
  localparam logic [3:0] REG_DOT_TIME = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // field positions and reset values
  localparam int CTRL_FILTER_BIT = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CURSOR_TIME_RESET = 16'h0100;
  localparam logic [15:0] DOT_TIME_RESET = 16'h0040;
  // alphanumeric sequence states
  typedef enum logic [1:0] {SDV_A_IDLE, SDV_A_SETTLE, SDV_A_FIRE} sdv_alpha_t;
endpackage : sdv_pkg

// [design/sdv_oneshot.sv]
// retriggerable-free one-shot timer with a programmable length
`timescale 1ns/1ps
module sdv_oneshot #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [W-1:0] len,
  // status
  output logic busy,
  output logic done
);
  logic [W-1:0] cnt_r;

  // a zero length behaves as one cycle so the timer never hangs
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_r <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy <= 1'b1;
        cnt_r <= (len == '0) ? '0 : W'(len - W'(1));
      end
      else if (busy)
      begin
        if (cnt_r == '0)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          cnt_r <= W'(cnt_r - W'(1));
      end
    end
  end

  property p_done_on_end;
    @(posedge clock) disable iff (rst) $fell(busy) |-> done;
  endproperty
  a_done_on_end: assert property (p_done_on_end) else $error("one-shot ended without done");
endmodule : sdv_oneshot

// [design/sdv_view_ctrl.sv]
// storage display view, hold, erase, long vector and alphanumeric trigger control
// Function
// R01 - flood_on stays true whenever view mode is active
// R02 - shift key or new information restarts the 100 second view timer
// R03 - running view timer keeps the hold oscillator disabled
// R04 - hold mode drives flood_on with a 12.3 percent high square wave
// R05 - hold longer than thirty minutes starts an automatic erase
// R06 - hardcopy_busy forces flood_on true regardless of hold oscillator
// R07 - host requests erase by pulling screen_clear_n low
// R08 - long vector pulse is latched for the rest of the vector period
// R09 - latched long vector blocks burn_guard_clock_n from cutting the beam
// R10 - vector_beam_on_n switches the writing beam during vector draws
// R11 - coordinate loaded unfiltered, trigger issued only after a short settle delay
// R12 - cursor and dot triggers last their software set intensity times
// R13 - filter enable smooths vectors, off lets output follow the converter
// R14 - erase is a 14 ms full write then 950 ms restore
// R15 - three bit origin shift counter wraps and advances each erase
// R16 - reset enters view mode, timer fresh, latch and hold count cleared
`timescale 1ns/1ps
module sdv_view_ctrl #(
  parameter logic [39:0] VIEW_CYC = 40'(sdv_pkg::VIEW_CYC),
  parameter logic [39:0] HOLD_LIMIT_CYC = 40'(sdv_pkg::HOLD_LIMIT_CYC),
  parameter logic [31:0] ERASE_WRITE_CYC = 32'(sdv_pkg::ERASE_WRITE_CYC),
  parameter logic [31:0] ERASE_RESTORE_CYC = 32'(sdv_pkg::ERASE_RESTORE_CYC),
  parameter logic [31:0] HOLD_PERIOD_CYC = 32'(sdv_pkg::HOLD_PERIOD_CYC)
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // view activity and hard copy
  input wire logic shift_key,
  input wire logic new_info,
  input wire logic hardcopy_busy,
  input wire logic screen_clear_n,
  // vector drawing
  input wire logic vector_active,
  input wire logic vector_draw,
  input wire logic long_vector_pulse,
  input wire logic burn_guard_clock_n,
  // alphanumeric request
  input wire logic alpha_load,
  input wire logic alpha_is_cursor,
  // tube control outputs
  output logic flood_on,
  output logic full_write,
  output logic erase_restore,
  output logic [2:0] origin_shift,
  output logic vector_beam_on_n,
  output logic filter_en,
  output logic cursor_write_trigger,
  output logic char_dot_trigger
);
  localparam logic [31:0] HOLD_HIGH_CYC =
    32'((64'(HOLD_PERIOD_CYC) * sdv_pkg::HOLD_DUTY_PERMILLE) / 1000);

  logic [39:0] view_cnt_r;
  logic [39:0] hold_dur_r;
  logic [31:0] hold_ph_r;
  logic auto_erase_r;
  logic long_vec_r;
  logic [15:0] ctrl_r;
  logic [15:0] cursor_time_r;
  logic [15:0] dot_time_r;
  logic is_cursor_r;
  sdv_pkg::sdv_alpha_t alpha_r;
  logic view_mode;
  logic erase_req;
  logic erase_start;
  logic write_busy;
  logic write_done;
  logic restore_busy;
  logic restore_done;
  logic settle_busy;
  logic settle_done;
  logic fire_busy;
  logic alpha_start;
  logic [31:0] fire_len;
  logic erasing;
  logic long_vec_nxt;

  assign view_mode = (view_cnt_r != '0);
  assign erasing = write_busy | restore_busy;
  // host request is a level; it is ignored while write or restore runs, but a level held into the idle cycle between them restarts the write
  assign erase_req = ~screen_clear_n | auto_erase_r; // R07 R05
  assign erase_start = erase_req & ~erasing;
  assign alpha_start = alpha_load & (alpha_r == sdv_pkg::SDV_A_IDLE);
  assign fire_len = {16'h0000, is_cursor_r ? cursor_time_r : dot_time_r};
  // clear wins over set: a pulse outside the vector period is not latched
  assign long_vec_nxt = vector_active & (long_vec_r | long_vector_pulse); // R08

  // register writes
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= sdv_pkg::CTRL_RESET;
      cursor_time_r <= sdv_pkg::CURSOR_TIME_RESET;
      dot_time_r <= sdv_pkg::DOT_TIME_RESET;
    end
    else if (wr)
    begin
      case (addr)
        sdv_pkg::REG_CTRL: ctrl_r <= wdata & 16'h0001;
        sdv_pkg::REG_CURSOR_TIME: cursor_time_r <= wdata;
        sdv_pkg::REG_DOT_TIME: dot_time_r <= wdata;
        default: ;
      endcase
    end
  end

  // register reads answer one cycle later; unmapped offsets read zero
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata <= 16'h0000;
    else if (rd)
    begin
      case (addr)
        sdv_pkg::REG_CTRL: rdata <= ctrl_r;
        sdv_pkg::REG_CURSOR_TIME: rdata <= cursor_time_r;
        sdv_pkg::REG_DOT_TIME: rdata <= dot_time_r;
        sdv_pkg::REG_STATUS: rdata <= {8'h00, origin_shift, long_vec_r, restore_busy,
          write_busy, ~view_mode, view_mode};
        default: rdata <= 16'h0000;
      endcase
    end
    else
      rdata <= 16'h0000;
  end

  // view timer; a finished erase counts as new information on the tube
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      view_cnt_r <= VIEW_CYC; // R16
    else if (shift_key || new_info || restore_done)
      view_cnt_r <= VIEW_CYC; // R02
    else if (view_mode)
      view_cnt_r <= 40'(view_cnt_r - 40'd1);
  end

  // hold oscillator phase, held at zero while the view timer runs
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      hold_ph_r <= '0;
    else if (view_mode)
      hold_ph_r <= '0; // R03
    else if (hold_ph_r == 32'(HOLD_PERIOD_CYC - 32'd1))
      hold_ph_r <= '0;
    else
      hold_ph_r <= 32'(hold_ph_r + 32'd1);
  end

  // hold duration; crossing the limit fires one automatic erase
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hold_dur_r <= '0; // R16
      auto_erase_r <= 1'b0;
    end
    else
    begin
      auto_erase_r <= 1'b0;
      if (view_mode || erasing)
        hold_dur_r <= '0;
      else if (hold_dur_r == HOLD_LIMIT_CYC)
      begin
        hold_dur_r <= '0;
        auto_erase_r <= 1'b1; // R05
      end
      else
        hold_dur_r <= 40'(hold_dur_r + 40'd1);
    end
  end

  // flood guns: view, hard copy or the high share of the hold wave
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flood_on <= 1'b1;
    else
      flood_on <= view_mode | hardcopy_busy | (hold_ph_r < HOLD_HIGH_CYC); // R01 R06 R04
  end

  // erase phases: full write then erase and restore
  sdv_oneshot #(.W(32)) u_write (
    .clock(clock),
    .rst(rst),
    .start(erase_start),
    .len(ERASE_WRITE_CYC),
    .busy(write_busy),
    .done(write_done)
  );
  sdv_oneshot #(.W(32)) u_restore (
    .clock(clock),
    .rst(rst),
    .start(write_done),
    .len(ERASE_RESTORE_CYC),
    .busy(restore_busy),
    .done(restore_done)
  );

  // erase outputs and the origin shift counter
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      full_write <= 1'b0;
      erase_restore <= 1'b0;
      origin_shift <= 3'h0;
    end
    else
    begin
      full_write <= write_busy; // R14
      erase_restore <= restore_busy; // R14
      if (erase_start)
        origin_shift <= 3'(origin_shift + 3'd1); // R15
    end
  end

  // long vector latch and beam control
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      long_vec_r <= 1'b0; // R16
      vector_beam_on_n <= 1'b1;
    end
    else
    begin
      long_vec_r <= long_vec_nxt;
      // burn guard only cuts the beam when no long vector is held
      vector_beam_on_n <= ~(vector_draw & (long_vec_nxt | burn_guard_clock_n)); // R09 R10
    end
  end

  // alphanumeric sequence: unfiltered load, settle, then one intensity pulse
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      alpha_r <= sdv_pkg::SDV_A_IDLE;
      is_cursor_r <= 1'b0;
    end
    else
    begin
      case (alpha_r)
        sdv_pkg::SDV_A_IDLE:
          if (alpha_load)
          begin
            alpha_r <= sdv_pkg::SDV_A_SETTLE;
            is_cursor_r <= alpha_is_cursor;
          end
        sdv_pkg::SDV_A_SETTLE:
          if (settle_done)
            alpha_r <= sdv_pkg::SDV_A_FIRE; // R11
        sdv_pkg::SDV_A_FIRE:
          if (!fire_busy && !settle_done)
            alpha_r <= sdv_pkg::SDV_A_IDLE;
        default: alpha_r <= sdv_pkg::SDV_A_IDLE;
      endcase
    end
  end

  sdv_oneshot #(.W(32)) u_settle (
    .clock(clock),
    .rst(rst),
    .start(alpha_start),
    .len(sdv_pkg::SETTLE_CYC),
    .busy(settle_busy),
    .done(settle_done)
  );
  sdv_oneshot #(.W(32)) u_fire (
    .clock(clock),
    .rst(rst),
    .start(settle_done),
    .len(fire_len),
    .busy(fire_busy),
    .done()
  );

  // trigger and filter outputs; filtering is forced off for the whole alpha sequence
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cursor_write_trigger <= 1'b0;
      char_dot_trigger <= 1'b0;
      filter_en <= 1'b0;
    end
    else
    begin
      cursor_write_trigger <= fire_busy & is_cursor_r; // R12
      char_dot_trigger <= fire_busy & ~is_cursor_r; // R12
      filter_en <= ctrl_r[sdv_pkg::CTRL_FILTER_BIT] & (alpha_r == sdv_pkg::SDV_A_IDLE)
        & ~alpha_load; // R13 R11
    end
  end

  // checks
  property p_view_flood;
    @(posedge clock) disable iff (rst) view_mode |=> flood_on;
  endproperty
  a_view_flood: assert property (p_view_flood) else $error("flood off in view mode"); // R01
  property p_view_restart;
    @(posedge clock) disable iff (rst) (shift_key || new_info) |=> view_mode [*8];
  endproperty
  a_view_restart: assert property (p_view_restart) else $error("view not held"); // R02
  property p_osc_off;
    @(posedge clock) disable iff (rst) view_mode |=> hold_ph_r == '0;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("hold oscillator ran in view"); // R03
  property p_hold_wave;
    @(posedge clock) disable iff (rst) (!view_mode && !hardcopy_busy)
      |=> flood_on == ($past(hold_ph_r) < HOLD_HIGH_CYC);
  endproperty
  a_hold_wave: assert property (p_hold_wave) else $error("hold wave wrong"); // R04
  property p_auto_erase;
    @(posedge clock) disable iff (rst) auto_erase_r && !erasing |=> write_busy;
  endproperty
  a_auto_erase: assert property (p_auto_erase) else $error("auto erase missed"); // R05
  property p_hardcopy;
    @(posedge clock) disable iff (rst) hardcopy_busy |=> flood_on;
  endproperty
  a_hardcopy: assert property (p_hardcopy) else $error("flood off in hard copy"); // R06
  property p_latch_hold;
    @(posedge clock) disable iff (rst) long_vec_r && vector_active |=> long_vec_r;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("long vector latch lost"); // R08
  property p_guard_blocked;
    @(posedge clock) disable iff (rst) (long_vec_r && vector_active && vector_draw)
      |=> !vector_beam_on_n;
  endproperty
  a_guard_blocked: assert property (p_guard_blocked) else $error("beam cut on long vector"); // R09
  property p_beam_off;
    @(posedge clock) disable iff (rst) !vector_draw |=> vector_beam_on_n;
  endproperty
  a_beam_off: assert property (p_beam_off) else $error("beam on without draw"); // R10
  property p_trig_unfiltered;
    @(posedge clock) disable iff (rst) (cursor_write_trigger || char_dot_trigger) |-> !filter_en;
  endproperty
  a_trig_unfiltered: assert property (p_trig_unfiltered) else $error("trigger while filtered"); // R11
  property p_erase_order;
    @(posedge clock) disable iff (rst) $fell(write_busy) |=> restore_busy;
  endproperty
  a_erase_order: assert property (p_erase_order) else $error("restore did not follow"); // R14
  property p_origin_step;
    @(posedge clock) disable iff (rst) erase_start |=> origin_shift == 3'($past(origin_shift) + 3'd1);
  endproperty
  a_origin_step: assert property (p_origin_step) else $error("origin shift not advanced"); // R15
  c_erase: cover property (@(posedge clock) disable iff (rst) restore_done);
  c_hold: cover property (@(posedge clock) disable iff (rst) !view_mode && !flood_on);
  c_cursor: cover property (@(posedge clock) disable iff (rst) cursor_write_trigger);
  c_long: cover property (@(posedge clock) disable iff (rst) long_vec_r && vector_draw);
endmodule : sdv_view_ctrl

// [verif/sdv_host_model.sv]
// host side model driving the register port and the erase request line
`timescale 1ns/1ps
module sdv_host_model (
  // clock
  input wire logic clock,
  // register port
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [15:0] rdata,
  // erase request, active low
  output logic screen_clear_n
);
  // idle levels at time zero
  initial
  begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    screen_clear_n = 1'b1;
  end

  // released lines toggle so a stale value never passes for a fresh one
  task automatic release_bus();
    addr <= ~addr;
    wdata <= ~wdata;
  endtask : release_bus

  // one cycle write strobe beside address and data
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    release_bus();
  endtask : reg_write

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    release_bus();
    @(negedge clock);
    d = rdata;
  endtask : reg_read

  // erase request: one cycle low, released well before the erase ends
  task automatic erase_req();
    @(posedge clock);
    screen_clear_n <= 1'b0;
    @(posedge clock);
    screen_clear_n <= 1'b1;
  endtask : erase_req
endmodule : sdv_host_model

// [verif/test_sdv_view_ctrl.sv]
// self-checking bench for view, hold, erase, vector and alphanumeric control
`timescale 1ns/1ps
module test_sdv_view_ctrl;
  // shortened counts handed to the design, expectations derived from them
  localparam logic [31:0] WR_N = 32'h0000_0014;
  localparam logic [31:0] RS_N = 32'h0000_0032;
  localparam logic [31:0] HIGH_N = 32'h0000_007b;
  localparam logic [31:0] SET_N = 32'h0000_00f0;
  localparam logic [31:0] AUTO_LO = 32'h0000_0c76;
  localparam logic [31:0] MAX_CYC = 32'h0000_4e20;
  typedef struct packed {logic [3:0] a; logic we; logic [15:0] wd; logic [15:0] exp;} sdv_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic shift_key = 1'b0;
  logic new_info = 1'b0;
  logic hardcopy_busy = 1'b0;
  logic vector_active = 1'b0;
  logic vector_draw = 1'b0;
  logic long_vector_pulse = 1'b0;
  logic burn_guard_clock_n = 1'b1;
  logic alpha_load = 1'b0;
  logic alpha_is_cursor = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic screen_clear_n;
  logic flood_on;
  logic full_write;
  logic erase_restore;
  logic [2:0] origin_shift;
  logic vector_beam_on_n;
  logic filter_en;
  logic cursor_write_trigger;
  logic char_dot_trigger;
  int n_errors = 0;
  int checked = 0;
  logic [31:0] cyc = 32'h0000_0000;
  logic [31:0] t0;
  logic [31:0] t1;
  logic [31:0] k;
  logic [15:0] rv;
  sdv_row_t rows [0:8];

  sdv_view_ctrl #(.VIEW_CYC(40'h00_0000_00c8), .HOLD_LIMIT_CYC(40'h00_0000_0bb8),
    .ERASE_WRITE_CYC(32'h0000_0014), .ERASE_RESTORE_CYC(32'h0000_0032),
    .HOLD_PERIOD_CYC(32'h0000_03e8)) dut_u (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .shift_key(shift_key),
    .new_info(new_info), .hardcopy_busy(hardcopy_busy), .screen_clear_n(screen_clear_n),
    .vector_active(vector_active), .vector_draw(vector_draw),
    .long_vector_pulse(long_vector_pulse), .burn_guard_clock_n(burn_guard_clock_n),
    .alpha_load(alpha_load), .alpha_is_cursor(alpha_is_cursor), .flood_on(flood_on),
    .full_write(full_write), .erase_restore(erase_restore), .origin_shift(origin_shift),
    .vector_beam_on_n(vector_beam_on_n), .filter_en(filter_en),
    .cursor_write_trigger(cursor_write_trigger), .char_dot_trigger(char_dot_trigger));

  sdv_host_model host_u (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .screen_clear_n(screen_clear_n));

  // 125 MHz clock
  always #4 clock = ~clock;

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // hang guard: a stuck wait would otherwise run forever
  always @(posedge clock)
  begin
    cyc <= cyc + 32'h0000_0001;
    if (cyc == MAX_CYC)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // count cycles of a level on flood_on over a window
  task automatic flood_high(input int n);
    k = 32'h0000_0000;
    repeat (n)
    begin
      @(negedge clock);
      if (flood_on === 1'b1)
        k++;
    end
  endtask : flood_high

  // bounded waits, so a missing erase shows as a zero length
  task automatic erase_check(input logic [2:0] os, input int lim);
    k = 32'h0000_0000;
    while (full_write !== 1'b1 && k < lim)
    begin
      @(negedge clock);
      k++;
    end
    t1 = cyc;
    chk(32'(origin_shift), 32'(os));
    k = 32'h0000_0000;
    while (full_write === 1'b1 && k < 100)
    begin
      @(negedge clock);
      k++;
    end
    chk(k, WR_N);
    // restore starts off the write done pulse, one idle cycle after the write phase
    @(negedge clock);
    chk(32'(erase_restore), 32'h0000_0001);
    k = 32'h0000_0000;
    while (erase_restore === 1'b1 && k < 100)
    begin
      @(negedge clock);
      k++;
    end
    chk(k, RS_N);
  endtask : erase_check

  initial
  begin
    rows[0] = '{4'h0, 1'b0, 16'h0000, 16'h0000};
    rows[1] = '{4'h4, 1'b0, 16'h0000, 16'h0100};
    rows[2] = '{4'h8, 1'b0, 16'h0000, 16'h0040};
    rows[3] = '{4'hc, 1'b0, 16'h0000, 16'h0001};
    rows[4] = '{4'h0, 1'b1, 16'hffff, 16'h0001};
    rows[5] = '{4'h4, 1'b1, 16'h0003, 16'h0003};
    rows[6] = '{4'h8, 1'b1, 16'h0002, 16'h0002};
    rows[7] = '{4'h6, 1'b1, 16'h1234, 16'h0000};
    rows[8] = '{4'hc, 1'b1, 16'hffff, 16'h0001};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk(32'({flood_on, vector_beam_on_n, full_write, erase_restore, origin_shift,
      cursor_write_trigger, char_dot_trigger}), 32'h0000_0180);
    // register rows: reset values, kept bits, unmapped and read-only places
    foreach (rows[i])
    begin
      if (rows[i].we)
        host_u.reg_write(rows[i].a, rows[i].wd);
      host_u.reg_read(rows[i].a, rv);
      chk(32'(rv), 32'(rows[i].exp));
    end
    chk(32'(filter_en), 32'h0000_0001);
    $display("test registers done");
    // vector beam, guard and long-vector latch
    @(posedge clock);
    vector_active <= 1'b1;
    vector_draw <= 1'b1;
    repeat (2) @(negedge clock);
    chk(32'(vector_beam_on_n), 32'h0000_0000);
    @(posedge clock);
    burn_guard_clock_n <= 1'b0;
    repeat (2) @(negedge clock);
    chk(32'(vector_beam_on_n), 32'h0000_0001);
    @(posedge clock);
    burn_guard_clock_n <= 1'b1;
    long_vector_pulse <= 1'b1;
    @(posedge clock);
    long_vector_pulse <= 1'b0;
    burn_guard_clock_n <= 1'b0;
    repeat (6) @(negedge clock);
    chk(32'(vector_beam_on_n), 32'h0000_0000);
    @(posedge clock);
    vector_active <= 1'b0;
    repeat (2) @(negedge clock);
    chk(32'(vector_beam_on_n), 32'h0000_0001);
    @(posedge clock);
    burn_guard_clock_n <= 1'b1;
    vector_draw <= 1'b0;
    repeat (2) @(negedge clock);
    chk(32'(vector_beam_on_n), 32'h0000_0001);
    $display("test vector done");
    // cursor then dot: settle with filter off, then timed trigger
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clock);
      alpha_load <= 1'b1;
      alpha_is_cursor <= (i == 0);
      @(posedge clock);
      alpha_load <= 1'b0;
      @(negedge clock);
      chk(32'(filter_en), 32'h0000_0000);
      k = 32'h0000_0000;
      while ((i == 0 ? cursor_write_trigger : char_dot_trigger) !== 1'b1 && k < 400)
      begin
        @(negedge clock);
        k++;
      end
      chk(32'(k >= SET_N && k < 400), 32'h0000_0001);
      chk(32'(i == 0 ? char_dot_trigger : cursor_write_trigger), 32'h0000_0000);
      k = 32'h0000_0000;
      while ((i == 0 ? cursor_write_trigger : char_dot_trigger) === 1'b1 && k < 20)
      begin
        @(negedge clock);
        k++;
      end
      chk(k, i == 0 ? 32'h0000_0003 : 32'h0000_0002);
      repeat (4) @(negedge clock);
      chk(32'(filter_en), 32'h0000_0001);
    end
    $display("test alpha done");
    host_u.erase_req();
    erase_check(3'h1, 10);
    $display("test erase done");
    // view timer restarts, then hold wave, then automatic erase
    @(posedge clock);
    new_info <= 1'b1;
    @(posedge clock);
    new_info <= 1'b0;
    flood_high(150);
    chk(k, 32'h0000_0096);
    @(posedge clock);
    shift_key <= 1'b1;
    t0 = cyc;
    @(posedge clock);
    shift_key <= 1'b0;
    flood_high(190);
    chk(k, 32'h0000_00be);
    repeat (30) @(negedge clock);
    flood_high(1000);
    chk(k, HIGH_N);
    erase_check(3'h2, 3000);
    chk(32'((t1 - t0 - AUTO_LO) < 32'h0000_0028), 32'h0000_0001);
    $display("test view hold done");
    repeat (400) @(negedge clock);
    @(posedge clock);
    hardcopy_busy <= 1'b1;
    repeat (2) @(negedge clock);
    flood_high(300);
    chk(k, 32'h0000_012c);
    @(posedge clock);
    hardcopy_busy <= 1'b0;
    $display("test hardcopy done");
    // second reset in mid-run clears the origin shift and restores view
    @(posedge clock);
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    host_u.reg_read(4'hc, rv);
    chk(32'(rv), 32'h0000_0001);
    chk(32'(flood_on), 32'h0000_0001);
    $display("test reset done");
    give_verdict();
  end
endmodule : test_sdv_view_ctrl
